// >>> swc_defs.svh
// constants for the switch control register block
//
// Behaviour
// - control register at offset 0x20, resets to 0x00, all switches open
// - bits 7:6 read-only error code, 00 means no fault, others fault
// - bits 5:4 reserved, read zero, host writes zeros there
// - bit 3 closes channel four when 1, reads back last written
// - bit 2 holds channel three closed when 1, open when 0
// - bit 1 holds channel two closed when 1, open when 0
// - bit 0 holds channel one closed when 1, channels independent
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
`define SWC_CTRL_OFFSET   12'h020
`define SWC_IRQ_STAT_OFF  12'h024
`define SWC_IRQ_MASK_OFF  12'h028
`define SWC_CTRL_RESET    8'h00
`define SWC_CH_MSB        3
`define SWC_CH_ONE_BIT    0
`define SWC_CH_TWO_BIT    1
`define SWC_CH_THREE_BIT  2
`define SWC_CH_FOUR_BIT   3
`define SWC_RSV_MSB       5
`define SWC_RSV_LSB       4
`define SWC_ERR_MSB       7
`define SWC_ERR_LSB       6
`define SWC_NO_ERR        2'h0
`define SWC_IRQ_BITS      2
`define SWC_IRQ_FAULT     0
`define SWC_IRQ_CHG       1
`endif

// >>> swc_pkg.sv
// types shared by the switch control register block
package swc_pkg;
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } swc_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } swc_apb_rsp_t;
    typedef struct packed {
        logic [1:0] err;
        logic [1:0] rsv;
        logic [3:0] ch;
    } swc_ctrl_t;
endpackage : swc_pkg

// >>> swc_top.sv
// apb register bank driving four switch channels with fault reporting
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_top #(
    parameter int CH_N = 4
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    input  wire swc_pkg::swc_apb_req_t apb_req,
    output swc_pkg::swc_apb_rsp_t      apb_rsp,
    input  wire logic [1:0]            fault_code,
    output logic [CH_N-1:0]            channel_close,
    output logic                       irq
);
    import swc_pkg::*;

    logic [CH_N-1:0]          ch_reg;
    logic [1:0]               err_reg;
    logic [`SWC_IRQ_BITS-1:0] stat_reg;
    logic [`SWC_IRQ_BITS-1:0] mask_reg;
    logic [`SWC_IRQ_BITS-1:0] ev;
    logic [`SWC_IRQ_BITS-1:0] w1c;
    logic                     acc;
    logic                     wr;
    logic                     hit_ctrl;
    logic                     hit_stat;
    logic                     hit_mask;
    logic [31:0]              rd_next;
    logic                     launch;
    logic                     mapped;

    // single-cycle access: answered in the first access-phase cycle
    // a transfer is launched while selected and not yet answered, so a
    // setup edge lost to a low enable is picked up again in the access phase
    assign launch   = apb_req.psel && !apb_rsp.pready;
    assign acc      = apb_req.psel && apb_req.penable && apb_rsp.pready && clk_en;
    assign wr       = acc && apb_req.pwrite;
    assign hit_ctrl = apb_req.paddr == `SWC_CTRL_OFFSET;
    assign hit_stat = apb_req.paddr == `SWC_IRQ_STAT_OFF;
    assign hit_mask = apb_req.paddr == `SWC_IRQ_MASK_OFF;
    assign mapped   = hit_ctrl || hit_stat || hit_mask;

    // channel bits, each stored independently; only low bits take writes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch_reg <= CH_N'(`SWC_CTRL_RESET);
        end else if (wr && hit_ctrl) begin
            ch_reg <= apb_req.pwdata[CH_N-1:0];
        end
    end

    // error field mirrors internal fault code, never bus writes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_reg <= `SWC_NO_ERR;
        end else if (clk_en) begin
            err_reg <= fault_code;
        end
    end

    // channel drive straight from flops, one per channel
    genvar gi;
    generate
        for (gi = 0; gi < CH_N; gi++) begin : g_ch
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    channel_close[gi] <= 1'b0;
                end else if (clk_en) begin
                    channel_close[gi] <= ch_reg[gi];
                end
            end
        end
    endgenerate

    // events: new fault appears, or software changes channel state
    assign ev[`SWC_IRQ_FAULT] = clk_en && (fault_code != `SWC_NO_ERR)
                                && (err_reg == `SWC_NO_ERR);
    assign ev[`SWC_IRQ_CHG]   = wr && hit_ctrl && (apb_req.pwdata[CH_N-1:0] != ch_reg);
    assign w1c = (wr && hit_stat) ? apb_req.pwdata[`SWC_IRQ_BITS-1:0] : '0;

    // sticky status; a set in the clearing cycle wins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_reg <= '0;
        end else if (clk_en) begin
            stat_reg <= (stat_reg & ~w1c) | ev;
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= '0;
        end else if (wr && hit_mask) begin
            mask_reg <= apb_req.pwdata[`SWC_IRQ_BITS-1:0];
        end
    end

    // registered irq level, one cycle behind status
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(stat_reg & mask_reg);
        end
    end

    // read mux; reserved bits always zero, unmapped reads zero
    always_comb begin
        rd_next = '0;
        if (hit_ctrl) begin
            rd_next[`SWC_ERR_MSB:`SWC_ERR_LSB] = err_reg;
            rd_next[`SWC_RSV_MSB:`SWC_RSV_LSB] = 2'h0;
            rd_next[CH_N-1:0] = ch_reg;
        end else if (hit_stat) begin
            rd_next[`SWC_IRQ_BITS-1:0] = stat_reg;
        end else if (hit_mask) begin
            rd_next[`SWC_IRQ_BITS-1:0] = mask_reg;
        end
    end

    // response flops: pready pulses for one enabled cycle per access
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            apb_rsp <= '0;
        end else if (clk_en) begin
            apb_rsp.pready  <= launch;
            // refused offsets answer with an error rather than a stall
            apb_rsp.pslverr <= launch && !mapped;
            // read data latched at launch so it stands through the access
            if (launch && !apb_req.pwrite) begin
                apb_rsp.prdata <= rd_next;
            end
        end
    end

    // channels open on the first edge out of reset
    AST_RESET_OPEN: assert property (@(posedge ref_clk)
        $rose(reset_n) |-> channel_close == '0)
        else $error("channels not open after reset");

    // error field read back as captured
    AST_ERR_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
        apb_rsp.pready && hit_ctrl && !apb_req.pwrite
        |-> apb_rsp.prdata[`SWC_ERR_MSB:`SWC_ERR_LSB] == $past(err_reg))
        else $error("error field read mismatch");

    // reserved positions never read as one
    AST_RSV_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
        apb_rsp.prdata[`SWC_RSV_MSB:`SWC_RSV_LSB] == 2'h0)
        else $error("reserved bits not zero");

    // channel four bit stores what was written
    AST_CH4_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr && hit_ctrl
        |=> ch_reg[`SWC_CH_FOUR_BIT] == $past(apb_req.pwdata[`SWC_CH_FOUR_BIT]))
        else $error("channel four bit not stored");

    // channel three pin follows its bit
    AST_CH3_DRIVE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en |=> channel_close[`SWC_CH_THREE_BIT] == $past(ch_reg[`SWC_CH_THREE_BIT]))
        else $error("channel three drive wrong");

    // channel two pin reaches written value two edges on
    AST_CH2_DRIVE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr && hit_ctrl ##1 clk_en
        |=> channel_close[`SWC_CH_TWO_BIT] == $past(apb_req.pwdata[`SWC_CH_TWO_BIT], 2))
        else $error("channel two drive wrong");

    // channel one holds without a control write
    AST_CH1_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !(wr && hit_ctrl) |=> $stable(ch_reg[`SWC_CH_ONE_BIT]))
        else $error("channel one changed without write");

    // error field tracks the internal code only
    AST_ERR_NOWRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en |=> err_reg == $past(fault_code))
        else $error("error field not tracking fault");

    // irq is the registered or of unmasked status
    AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en |=> irq == $past(|(stat_reg & mask_reg)))
        else $error("irq level wrong");

    // every launch with enable high answered at the next edge
    AST_READY_NEXT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en |=> apb_rsp.pready)
        else $error("ready missing after launch");

    // ready stands for one enabled cycle only
    AST_READY_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        apb_rsp.pready && clk_en |=> !apb_rsp.pready)
        else $error("ready held too long");

    // no ready without a selected transfer
    AST_READY_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !apb_req.psel && clk_en |=> !apb_rsp.pready)
        else $error("ready while idle");

    // a write lands only at the answering edge
    AST_WRITE_READY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr |-> apb_rsp.pready)
        else $error("write without ready");

    // unmapped offsets are refused with an error
    AST_SLVERR_MAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en && !mapped |=> apb_rsp.pslverr)
        else $error("unmapped access not refused");

    // the control register never reports an error response
    AST_SLVERR_CTRL: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en && hit_ctrl |=> !apb_rsp.pslverr)
        else $error("control access refused");

    // error response stands for one enabled cycle only
    AST_SLVERR_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        apb_rsp.pslverr && clk_en |=> !apb_rsp.pslverr)
        else $error("error response held too long");

    // unmapped reads return zero
    AST_UNMAP_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en && !apb_req.pwrite && !mapped |=> apb_rsp.prdata == '0)
        else $error("unmapped read not zero");

    // channel bits read back as stored
    AST_CTRL_READ_CH: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en && !apb_req.pwrite && hit_ctrl
        |=> apb_rsp.prdata[CH_N-1:0] == $past(ch_reg))
        else $error("channel bits read mismatch");

    // nothing above the error field reads as one
    AST_CTRL_UPPER: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en && !apb_req.pwrite && hit_ctrl
        |=> (apb_rsp.prdata >> (`SWC_ERR_MSB + 1)) == '0)
        else $error("upper read bits not zero");

    // status register read back as stored
    AST_STAT_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en && !apb_req.pwrite && hit_stat
        |=> apb_rsp.prdata[`SWC_IRQ_BITS-1:0] == $past(stat_reg))
        else $error("status read mismatch");

    // mask register read back as stored
    AST_MASK_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
        launch && clk_en && !apb_req.pwrite && hit_mask
        |=> apb_rsp.prdata[`SWC_IRQ_BITS-1:0] == $past(mask_reg))
        else $error("mask read mismatch");

    // read data holds between reads
    AST_PRDATA_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !(launch && clk_en && !apb_req.pwrite) |=> $stable(apb_rsp.prdata))
        else $error("read data moved without a read");

    // a control write stores all channel bits at once
    AST_CH_WRITE_ALL: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr && hit_ctrl |=> ch_reg == $past(apb_req.pwdata[CH_N-1:0]))
        else $error("channel bits not stored");

    // writes elsewhere leave the channels alone
    AST_CH_NO_OTHER: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr && !hit_ctrl |=> $stable(ch_reg))
        else $error("channels changed by other write");

    // every pin follows its own bit
    AST_CH_TO_PIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en |=> channel_close == $past(ch_reg))
        else $error("channel pins do not follow bits");

    // an event always sets its sticky bit
    AST_STAT_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ev != '0) |=> (stat_reg & $past(ev)) == $past(ev))
        else $error("event lost");

    // a one written clears the bit unless an event lands too
    AST_STAT_W1C: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (w1c != '0) |=> (stat_reg & $past(w1c & ~ev)) == '0)
        else $error("status not cleared");

    // status holds without event or clear
    AST_STAT_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ev == '0) && (w1c == '0) |=> $stable(stat_reg))
        else $error("status moved on its own");

    // mask stores what was written
    AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr && hit_mask |=> mask_reg == $past(apb_req.pwdata[`SWC_IRQ_BITS-1:0]))
        else $error("mask not stored");

    // a clear mask keeps irq low
    AST_IRQ_MASKED: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mask_reg == '0) && clk_en |=> !irq)
        else $error("irq with all masked");

    // low enable holds every register and output
    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !clk_en |=> $stable(ch_reg) && $stable(err_reg) && $stable(stat_reg)
            && $stable(mask_reg) && $stable(irq) && $stable(channel_close)
            && $stable(apb_rsp))
        else $error("state moved while enable low");

    // all four channels closed together
    COV_CLOSE_ALL: cover property (@(posedge ref_clk) disable iff (!reset_n)
        channel_close == '1);

    // a fault reaching the irq pin
    COV_FAULT_IRQ: cover property (@(posedge ref_clk) disable iff (!reset_n)
        ev[`SWC_IRQ_FAULT] ##[1:4] irq);

    // a clear of a set status bit
    COV_W1C: cover property (@(posedge ref_clk) disable iff (!reset_n)
        wr && hit_stat && (stat_reg != '0));

    // a refused access
    COV_UNMAPPED: cover property (@(posedge ref_clk) disable iff (!reset_n)
        apb_rsp.pslverr);

    // enable dropping and coming back
    COV_FREEZE: cover property (@(posedge ref_clk) disable iff (!reset_n)
        !clk_en ##1 clk_en);
endmodule : swc_top

// >>> switch_control_register_bench.sv
// self-checking bench for the switch control register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module switch_control_register_bench;
    import swc_pkg::*;
    logic          ref_clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          clk_en  = 1'b1;
    swc_apb_req_t  req     = '0;
    swc_apb_rsp_t  rsp;
    logic [1:0]    fault_code = 2'h0;
    logic [3:0]    channel_close;
    logic          irq;
    logic [32:0]   exp_q[$];
    int            error_cnt  = 0;
    int            n_compared = 0;
    logic [3:0]    ch;
    logic [31:0]   r;
    logic [32:0]   exp_v;

    swc_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .apb_req(req),
        .apb_rsp(rsp), .fault_code(fault_code), .channel_close(channel_close), .irq(irq));

    // 40 ns period
    always #20 ref_clk = ~ref_clk;

    task print_verdict;
        $display("counts: compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // one apb transfer; reads note {pslverr, prdata} for the monitor
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
        int k;
        if (!w) exp_q.push_back(e);
        @(posedge ref_clk);
        req.paddr <= a; req.psel <= 1'b1; req.penable <= 1'b0; req.pwrite <= w; req.pwdata <= d;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        k = 0;
        do begin @(posedge ref_clk); k++; end while (rsp.pready !== 1'b1 && k < 50);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (k >= 50) begin error_cnt++; print_verdict(); end
    endtask : apb

    // monitor: read completions are taken off the queue in order
    always @(posedge ref_clk) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
            if (exp_q.size() == 0) begin error_cnt++; $display("ERROR read unexpected"); end
            else begin
                exp_v = exp_q.pop_front();
                `CHK("read", exp_v, {rsp.pslverr, rsp.prdata})
            end
        end
    end

    task settle;
        repeat (3) @(posedge ref_clk);
    endtask : settle

    initial begin
        void'($urandom(32'h1ce0));
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        apb(12'h020, 0, 0, 33'h0);
        `CHK("open", 4'h0, channel_close)
        $display("test reset done");
        // random writes with junk in bits 31:6, readback keeps only channels
        for (int i = 0; i < 12; i++) begin
            fault_code <= 2'($urandom);
            r = $urandom;
            r[5:4] = 2'b00;
            apb(12'h020, 1, r, 0);
            settle();
            ch = r[3:0];
            `CHK("chan", ch, channel_close)
            apb(12'h020, 0, 0, {25'h0, fault_code, 2'b00, ch});
        end
        $display("test random done");
        // each channel alone, others stay open
        for (int i = 0; i < 4; i++) begin
            apb(12'h020, 1, 32'h1 << i, 0);
            settle();
            `CHK("one", 4'h1 << i, channel_close)
        end
        apb(12'h030, 1, 32'hff, 0);
        apb(12'h030, 0, 0, {1'b1, 32'h0});
        apb(12'h020, 0, 0, {25'h0, fault_code, 2'b00, 4'h8});
        $display("test unmapped done");
        // fault event raises irq, mask hides it, w1c clears it
        fault_code <= 2'h0;
        settle();
        apb(12'h024, 1, 32'h3, 0);
        apb(12'h028, 1, 32'h1, 0);
        fault_code <= 2'h2;
        settle();
        `CHK("irq", 1'b1, irq)
        apb(12'h028, 1, 32'h0, 0);
        settle();
        `CHK("mask", 1'b0, irq)
        apb(12'h028, 1, 32'h1, 0);
        apb(12'h024, 1, 32'h1, 0);
        settle();
        `CHK("clr", 1'b0, irq)
        apb(12'h024, 0, 0, 33'h0);
        settle();
        `CHK("drain", 0, exp_q.size())
        $display("test irq done");
        // low enable freezes fault capture; the event lands once enabled
        fault_code <= 2'h0;
        settle();
        clk_en <= 1'b0;
        fault_code <= 2'h1;
        settle();
        `CHK("freeze", 1'b0, irq)
        clk_en <= 1'b1;
        settle();
        `CHK("thaw", 1'b1, irq)
        $display("test enable done");
        // reset in mid-run opens every channel and clears the mask
        apb(12'h020, 1, 32'hf, 0);
        settle();
        `CHK("pre", 4'hf, channel_close)
        reset_n <= 1'b0;
        fault_code <= 2'h0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        `CHK("rst", 4'h0, channel_close)
        `CHK("rstirq", 1'b0, irq)
        apb(12'h020, 0, 0, 33'h0);
        apb(12'h028, 0, 0, 33'h0);
        settle();
        `CHK("drain2", 0, exp_q.size())
        $display("test reset again done");
        print_verdict();
    end
endmodule : switch_control_register_bench
